/* logic/adcc_pkg.sv */
/*
 * Shared constants for the converter control block: register indices,
 * field positions, reset values, bus responses and timing counts.
 * Assumes a single 25 MHz core clock.
 */
package adcc_pkg;
	// ************************************************
	// Register map (byte address is four times index)
	// ************************************************
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_CTRL = 8'hC5;
	localparam logic [7:0] IDX_RESULT = 8'hC6;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hC7;
	localparam logic [7:0] IDX_IRQ_CLR = 8'hC8;
	localparam logic [7:0] IDX_IRQ_EN = 8'hC9;
	localparam logic [7:0] IDX_PORT = 8'hCA;

	// ************************************************
	// Control register fields and reset values
	// ************************************************
	localparam int CTRL_CHAN_LO = 0;
	localparam int CTRL_CHAN_HI = 1;
	localparam int CTRL_START = 3;
	localparam int CTRL_DONE = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam int IRQ_DONE_BIT = 0;

	// ************************************************
	// Bus responses
	// ************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int ACQ_TIME_NS = 2560;
	localparam int BIT_TIME_NS = 640;
	localparam logic [7:0] ACQ_CYC = 8'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] BIT_CYC = 8'((BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] CONV_MAX_CYC = 10'h258;

	typedef enum logic [1:0] {SAR_IDLE, SAR_ACQ, SAR_BIT} adcc_sar_e;
endpackage

/* logic/adcc_sync.sv */
/*
 * Three-stage input synchroniser for pins and the comparator.
 * Assumes its input is asynchronous to core_clk.
 */
`timescale 1ns/1ns
module adcc_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Shift chain, first stage read only by the second
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_out <= '0;
		else if (stage2 == stage3)
			sync_out <= stage3;
	end
endmodule

/* logic/adcc_sar.sv */
/*
 * Successive-approximation sequencer: acquisition window, then one
 * trial bit per step from the top bit down.
 * Assumes comp_hi is synchronised and settles within one bit step.
 */
`timescale 1ns/1ns
module adcc_sar
	import adcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic comp_hi,
	output logic sample_hold,
	output logic [7:0] dac_code,
	output logic [7:0] result,
	output logic done
);
	adcc_sar_e state;
	logic [7:0] cnt;
	logic [2:0] bit_idx;
	logic [7:0] decided;

	// Trial bit kept only if the input is above the trial level
	always_comb
	begin
		decided = dac_code;
		if (!comp_hi)
			decided[bit_idx] = 1'b0;
	end

	// Sequencer
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SAR_IDLE;
			cnt <= 8'h00;
			bit_idx <= 3'h0;
			sample_hold <= 1'b0;
			dac_code <= 8'h00;
			result <= RESULT_RESET;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (abort)
			begin
				state <= SAR_IDLE;
				sample_hold <= 1'b0;
			end
			else
			begin
				unique case (state)
					SAR_IDLE:
					begin
						if (start)
						begin
							state <= SAR_ACQ;
							cnt <= ACQ_CYC - 8'h01;
							sample_hold <= 1'b1;
						end
					end
					SAR_ACQ:
					begin
						if (cnt == 8'h00)
						begin
							state <= SAR_BIT;
							sample_hold <= 1'b0;
							bit_idx <= 3'h7;
							dac_code <= 8'h80;
							cnt <= BIT_CYC - 8'h01;
						end
						else
							cnt <= cnt - 8'h01;
					end
					SAR_BIT:
					begin
						if (cnt != 8'h00)
							cnt <= cnt - 8'h01;
						else if (bit_idx == 3'h0)
						begin
							state <= SAR_IDLE;
							dac_code <= decided;
							result <= decided;
							done <= 1'b1;
						end
						else
						begin
							dac_code <= decided | (8'h01 << (bit_idx - 3'h1));
							bit_idx <= bit_idx - 3'h1;
							cnt <= BIT_CYC - 8'h01;
						end
					end
				endcase
			end
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	a_done_after_lsb: assert property (@(posedge core_clk) disable iff (!rst_n)
		done |-> $past(state) == SAR_BIT && $past(bit_idx) == 3'h0)
		else $error("done without the last bit decided");
endmodule

/* logic/adcc_ctrl.sv */
/*
 * Converter control block: AXI4-Lite register slave, start and flag
 * interlocks, idle abort, pin read-back and the done interrupt.
 * Assumes idle_mode comes from core_clk logic; pins and comparator are
 * asynchronous.
 */
`timescale 1ns/1ns
// Contract
// - Exactly one of four inputs is routed by the channel field before conversion.
// - Result is eight bits found by successive approximation.
// - Writing start one begins acquisition; bit stays set until hardware ends it.
// - Conversion ends within 600 clock periods of its start.
// - No new start while busy; writing zero does not clear start.
// - On completion load result, set done flag, raise interrupt request.
// - Start is ignored while the done flag is set.
// - Done flag and result survive idle and power-down.
// - Entering idle aborts a running conversion.
// - Reset returns control to default and leaves converter inactive.
// - Port pins can be read digitally at any time.
// - The selected pin reads one while its conversion runs.
// - Channel field is bits 1:0; codes 0..3 pick inputs 0..3.
// - Result register is read only; writes do nothing.
module adcc_ctrl
	import adcc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic idle_mode,
	input wire logic [3:0] port_pin,
	input wire logic comp_in,
	output logic [1:0] mux_sel,
	output logic sample_hold,
	output logic [7:0] dac_code,
	output logic irq
);
	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] addr);
		reg_idx = addr[9:2];
	endfunction

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx >= IDX_CTRL) && (idx <= IDX_PORT);
	endfunction

	logic aw_got;
	logic w_got;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [7:0] widx;
	logic wr_ctrl;
	logic start_go;
	logic start_busy;
	logic done_flag;
	logic [7:0] result;
	logic [0:0] irq_stat;
	logic [0:0] irq_en;
	logic [3:0] pins;
	logic [3:0] port_view;
	logic comp_hi;
	logic sar_done;
	logic [7:0] sar_result;
	logic [9:0] busy_cnt;

	// ************************************************
	// Input synchronisers and sequencer
	// ************************************************
	adcc_sync #(.W(4)) u_pin_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(port_pin),
		.sync_out(pins)
	);

	adcc_sync #(.W(1)) u_comp_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(comp_in),
		.sync_out(comp_hi)
	);

	adcc_sar u_sar (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start_go),
		.abort(idle_mode),
		.comp_hi(comp_hi),
		.sample_hold(sample_hold),
		.dac_code(dac_code),
		.result(sar_result),
		.done(sar_done)
	);

	// ************************************************
	// Write channel
	// ************************************************
	// Write happens once address and data are both held
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign widx = reg_idx(aw_addr);
	assign wr_ctrl = wr_fire && (widx == IDX_CTRL) && w_strb[0];
	assign start_go = wr_ctrl && w_data[CTRL_START] && !start_busy
		&& !done_flag && !idle_mode;

	// Address capture
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			if (wr_fire)
				aw_got <= 1'b0;
			s_axi_awready <= !aw_got && !s_axi_bvalid;
		end
	end

	// Data capture
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			w_got <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_got <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			if (wr_fire)
				w_got <= 1'b0;
			s_axi_wready <= !w_got && !s_axi_bvalid;
		end
	end

	// Write response
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= idx_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ************************************************
	// Converter control state
	// ************************************************
	// Channel select, frozen while converting
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mux_sel <= CTRL_RESET[CTRL_CHAN_HI:CTRL_CHAN_LO];
		else if (wr_ctrl && !start_busy)
			mux_sel <= w_data[CTRL_CHAN_HI:CTRL_CHAN_LO];
	end

	// Start and busy bit
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			start_busy <= CTRL_RESET[CTRL_START];
		else if (start_go)
			start_busy <= 1'b1;
		else if (sar_done || idle_mode)
			start_busy <= 1'b0;
	end

	// Done flag, set wins over software clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			done_flag <= CTRL_RESET[CTRL_DONE];
		else if (sar_done)
			done_flag <= 1'b1;
		else if (wr_ctrl && !w_data[CTRL_DONE])
			done_flag <= 1'b0;
	end

	// Result, loaded only by the sequencer
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			result <= RESULT_RESET;
		else if (sar_done)
			result <= sar_result;
	end

	// ************************************************
	// Interrupt
	// ************************************************
	// Sticky status, write-one clear, set wins
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat <= 1'b0;
		else if (sar_done)
			irq_stat <= 1'b1;
		else if (wr_fire && widx == IDX_IRQ_CLR && w_strb[0] && w_data[IRQ_DONE_BIT])
			irq_stat <= 1'b0;
	end

	// Enable register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_en <= 1'b0;
		else if (wr_fire && widx == IDX_IRQ_EN && w_strb[0])
			irq_en <= w_data[IRQ_DONE_BIT];
	end

	// Level output
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= irq_stat[0] && irq_en[0];
	end

	// ************************************************
	// Read channel
	// ************************************************
	// Pin view, selected pin forced high while converting
	always_comb
	begin
		port_view = pins;
		if (start_busy)
			port_view[mux_sel] = 1'b1;
	end

	// Read data and response
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= idx_mapped(reg_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
			unique case (reg_idx(s_axi_araddr))
				IDX_CTRL: s_axi_rdata <= {27'h0, done_flag, start_busy, 1'b0, mux_sel};
				IDX_RESULT: s_axi_rdata <= {24'h0, result};
				IDX_IRQ_STAT: s_axi_rdata <= {31'h0, irq_stat};
				IDX_IRQ_EN: s_axi_rdata <= {31'h0, irq_en};
				IDX_PORT: s_axi_rdata <= {28'h0, port_view};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else
			s_axi_arready <= 1'b1;
	end

	// ************************************************
	// Checks
	// ************************************************
	// Cycles spent busy
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			busy_cnt <= 10'h000;
		else if (!start_busy)
			busy_cnt <= 10'h000;
		else
			busy_cnt <= busy_cnt + 10'h001;
	end

	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_start_sets_busy: assert property (start_go |=> start_busy && sample_hold)
		else $error("accepted start did not set busy");
	a_conv_time_bound: assert property (busy_cnt < CONV_MAX_CYC)
		else $error("conversion exceeded its time limit");
	a_no_restart: assert property (start_busy && wr_ctrl |=> start_busy || $past(sar_done))
		else $error("busy dropped by a software write");
	a_done_loads: assert property (sar_done |=> done_flag && result == $past(sar_result))
		else $error("completion did not load result and flag");
	a_flag_blocks: assert property (done_flag && wr_ctrl |=> !$rose(start_busy))
		else $error("start accepted while done flag set");
	a_flag_holds: assert property (done_flag && !wr_ctrl |=> done_flag)
		else $error("done flag lost without software clear");
	a_idle_abort: assert property (idle_mode && start_busy |=> !start_busy ##1 !sar_done)
		else $error("conversion not aborted by idle");
	a_pin_reads_one: assert property (start_busy |-> port_view[mux_sel])
		else $error("selected pin not read as one");
	a_chan_frozen: assert property (start_busy |=> $stable(mux_sel))
		else $error("channel changed during conversion");
	a_result_ro: assert property (!sar_done |=> $stable(result))
		else $error("result changed without completion");
	a_irq_follows: assert property (sar_done && irq_en[0] |-> ##2 irq)
		else $error("interrupt not raised on completion");

	c_full_conv: cover property (start_go ##[1:300] sar_done);
	c_idle_abort: cover property (start_busy && idle_mode);
	c_blocked_start: cover property (done_flag && wr_ctrl && w_data[CTRL_START]);
endmodule

/* tb/adcc_analog_model.sv */
/*
 * Analog side of the converter: four channel levels, the input mux, the
 * sample-hold and the comparator.
 * Assumes static levels; each input sits half an LSB above its code.
 */
`timescale 1ns/1ns
module adcc_analog_model
(
	input wire logic core_clk,
	input wire logic [31:0] levels,
	input wire logic [1:0] mux_sel,
	input wire logic sample_hold,
	input wire logic [7:0] dac_code,
	output logic comp_in
);
	logic [7:0] held = 8'h00;

	// Capture the routed input while acquiring
	always @(posedge core_clk)
	begin
		if (sample_hold)
			held <= levels[8*mux_sel +: 8];
	end

	// Half an LSB above the code, so equal trial reads high
	assign comp_in = (held >= dac_code);
endmodule

/* tb/adc_conversion_control_bench.sv */
/*
 * Self-checking bench: AXI4-Lite master tasks, conversions on all four
 * channels, interlocks, idle abort and the done interrupt.
 * Assumes the register map and timing of the shared package.
 */
`timescale 1ns/1ns
module adc_conversion_control_bench
	import adcc_pkg::*;
;
	logic core_clk, rst_n, idle_mode, comp_in, irq, sample_hold;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0] s_axi_wstrb, port_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp, mux_sel, rd_resp;
	logic [7:0] dac_code;
	int error_cnt = 0;
	int samples_checked = 0;
	int ch, n;
	localparam logic [31:0] LEVELS = 32'hFF01C35A;
	localparam logic [3:0] PINS = 4'h5;

	// ************************************************
	// Clock, design and analog side
	// ************************************************
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	adcc_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .idle_mode(idle_mode),
		.port_pin(port_pin), .comp_in(comp_in), .mux_sel(mux_sel), .sample_hold(sample_hold),
		.dac_code(dac_code), .irq(irq));

	adcc_analog_model analog (.core_clk(core_clk), .levels(LEVELS), .mux_sel(mux_sel),
		.sample_hold(sample_hold), .dac_code(dac_code), .comp_in(comp_in));

	// ************************************************
	// Bus tasks and checks
	// ************************************************
	function automatic logic [ADDR_W-1:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= ad(idx);
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Waits for the answer; only the watchdog ends a hang
		do
		begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
	endtask

	// Read: rready held until the data is seen
	task automatic rd(input logic [7:0] idx);
		@(posedge core_clk);
		s_axi_araddr <= ad(idx);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// Waits for the answer; only the watchdog ends a hang
		do
		begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_val = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		#(40 * 30000);
		error_cnt++;
		give_verdict();
	end

	// ************************************************
	// Test sequence
	// ************************************************
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		idle_mode = 1'b0;
		port_pin = PINS;
		rst_n = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(IDX_CTRL); chk(rd_val, 32'h0);
		rd(IDX_RESULT); chk(rd_val, 32'h0);
		rd(8'hD0); chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
		wr(IDX_IRQ_EN, 32'h1);
		for (ch = 0; ch < 4; ch++)
		begin
			wr(IDX_CTRL, 32'h8 | ch);
			n = 0;
			rd(IDX_CTRL); chk(rd_val, 32'h8 | ch);
			wr(IDX_CTRL, ch);
			rd(IDX_CTRL); chk(rd_val, 32'h8 | ch);
			rd(IDX_PORT); chk(rd_val, 32'(PINS | (4'h1 << ch)));
			while (irq !== 1'b1 && n < 700)
			begin
				@(posedge core_clk);
				n++;
			end
			chk(32'(n < 560), 32'h1);
			rd(IDX_RESULT); chk(rd_val, 32'(LEVELS[8*ch +: 8]));
			rd(IDX_CTRL); chk(rd_val, 32'h10 | ch);
			rd(IDX_IRQ_STAT); chk(rd_val, 32'h1);
			rd(IDX_PORT); chk(rd_val, 32'(PINS));
			wr(IDX_CTRL, 32'h18 | ch);
			rd(IDX_CTRL); chk(rd_val, 32'h10 | ch);
			wr(IDX_RESULT, 32'hFF);
			rd(IDX_RESULT); chk(rd_val, 32'(LEVELS[8*ch +: 8]));
			wr(IDX_CTRL, ch);
			wr(IDX_IRQ_CLR, 32'h1);
			rd(IDX_CTRL); chk(rd_val, ch);
			chk({31'h0, irq}, 32'h0);
		end
		// Abort by idle, then start refused while idle
		wr(IDX_IRQ_EN, 32'h0);
		wr(IDX_CTRL, 32'h9);
		repeat (20) @(posedge core_clk);
		idle_mode <= 1'b1;
		rd(IDX_CTRL); chk(rd_val, 32'h1);
		rd(IDX_RESULT); chk(rd_val, 32'hFF);
		wr(IDX_CTRL, 32'h9);
		rd(IDX_CTRL); chk(rd_val, 32'h1);
		idle_mode <= 1'b0;
		// Masked completion, flag kept across idle, then unmask
		wr(IDX_CTRL, 32'hA);
		n = 0;
		rd_val = 32'h8;
		while (rd_val[CTRL_START] !== 1'b0 && n < 200)
		begin
			rd(IDX_CTRL);
			n++;
		end
		chk({31'h0, irq}, 32'h0);
		idle_mode <= 1'b1;
		rd(IDX_CTRL); chk(rd_val, 32'h12);
		rd(IDX_RESULT); chk(rd_val, 32'h01);
		rd(IDX_IRQ_STAT); chk(rd_val, 32'h1);
		idle_mode <= 1'b0;
		wr(IDX_IRQ_EN, 32'h1);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		give_verdict();
	end
endmodule
